/* File: hw/ipo_pkg.sv */
// Constants and types for the image port output control block
package ipo_pkg;
	// Register offsets; status offset is a local addition
	localparam logic [7:0] REG_FMT_POL  = 8'h85;
	localparam logic [7:0] REG_FIFO_ARB = 8'h86;
	localparam logic [7:0] REG_CLK_EN   = 8'h87;
	localparam logic [7:0] REG_STATUS   = 8'h8E;
	// Values after reset
	localparam logic [7:0] RST_FMT_POL  = 8'h00;
	localparam logic [7:0] RST_FIFO_ARB = 8'h00;
	localparam logic [7:0] RST_CLK_EN   = 8'h00;
	// Field positions, format and polarity register
	localparam int B_SWAP_LO  = 6;
	localparam int B_LIMIT    = 5;
	localparam int B_GP0_INV  = 4;
	localparam int B_GP1_INV  = 3;
	localparam int B_VREF_INV = 2;
	localparam int B_HREF_INV = 1;
	localparam int B_QUAL_INV = 0;
	// Field positions, FIFO flag and arbitration register
	localparam int B_ARB_LO   = 6;
	localparam int B_GP0_MSB  = 5;
	localparam int B_GP1_MSB  = 4;
	localparam int B_FULL_LO  = 2;
	localparam int B_EMPTY_LO = 0;
	// Field positions, clock phase and enable register
	localparam int B_GCK_LO   = 6;
	localparam int B_OCK_LO   = 4;
	localparam int B_PEN_LO   = 0;
	localparam logic [7:0] CLK_EN_RW_MASK = 8'hF3;
	// Clip bounds for video samples
	localparam logic [7:0] LIM_WIDE_LO   = 8'h01;
	localparam logic [7:0] LIM_WIDE_HI   = 8'hFE;
	localparam logic [7:0] LIM_NARROW_LO = 8'h08;
	localparam logic [7:0] LIM_NARROW_HI = 8'hF7;
	// FIFO thresholds in Dwords
	localparam logic [5:0] AE_LVL0 = 6'h10;
	localparam logic [5:0] AE_LVL1 = 6'h08;
	localparam logic [5:0] AE_LVL2 = 6'h04;
	localparam logic [5:0] AF_LVL0 = 6'h10;
	localparam logic [5:0] AF_LVL1 = 6'h18;
	localparam logic [5:0] AF_LVL2 = 6'h1C;
	localparam logic [5:0] AF_LVL3 = 6'h20;
	typedef enum logic [1:0] {ARB_OFF, ARB_VIDEO, ARB_TEXT, ARB_BOTH} ipo_arb_e;
	typedef enum logic [1:0] {PEN_OFF, PEN_ON, PEN_PIN_LOW, PEN_PIN_HIGH} ipo_pen_e;
	typedef enum logic [2:0] {GPF_FIELD, GPF_TASK, GPF_SLICED, GPF_ZERO,
		GPF_FILLED, GPF_OVFL, GPF_AFULL, GPF_AEMPTY} ipo_gpf_e;
endpackage

/* File: hw/ipo_top.sv */
// Image port output control: registers, link-side formatter and pin control
`timescale 1ns/1ns
module ipo_top
	import ipo_pkg::*;
(
	// Core clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register access
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// Core-domain settings held elsewhere
	input  wire logic [1:0]  gp0_func_lo,
	input  wire logic [1:0]  gp1_func_lo,
	input  wire logic        gated_clk_sel,
	// Link clock and scaler stream
	input  wire logic        link_clk,
	input  wire logic [31:0] vid_dword,
	input  wire logic        vid_valid,
	input  wire logic        vid_is_code,
	input  wire logic [31:0] txt_dword,
	input  wire logic        txt_valid,
	output logic             vid_take,
	output logic             txt_take,
	// Scaler reference and FIFO state
	input  wire logic        href_in,
	input  wire logic        vref_in,
	input  wire logic        field_id_in,
	input  wire logic        task_flag_in,
	input  wire logic        sliced_frame_in,
	input  wire logic        fifo_filled_in,
	input  wire logic        fifo_ovfl_in,
	input  wire logic [5:0]  fifo_level,
	// Port pins
	input  wire logic        port_tristate_pin,
	output logic [31:0]      port_data_out,
	output logic             data_qualifier_out,
	output logic             horiz_ref_out,
	output logic             vert_ref_out,
	output logic             gp_out0,
	output logic             gp_out1,
	output logic             port_clock_out,
	output logic             out_clk_delay,
	output logic             gated_clk_delay,
	output logic             port_oe_n
);
	import ipo_pkg::*;

	function automatic logic [7:0] clip(input logic [7:0] b, input logic narrow);
		logic [7:0] lo;
		logic [7:0] hi;
		lo = narrow ? LIM_NARROW_LO : LIM_WIDE_LO;
		hi = narrow ? LIM_NARROW_HI : LIM_WIDE_HI;
		clip = (b < lo) ? lo : ((b > hi) ? hi : b);
	endfunction

	function automatic logic [31:0] swap(input logic [31:0] d, input logic [1:0] s);
		case (s)
			2'h1:    swap = {d[23:16], d[31:24], d[7:0], d[15:8]};
			2'h2:    swap = {d[15:0], d[31:16]};
			2'h3:    swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
			default: swap = d;
		endcase
	endfunction

	function automatic logic gp_pick(input logic [2:0] f, input logic [5:0] flags);
		case (ipo_gpf_e'(f))
			GPF_FIELD:  gp_pick = flags[0];
			GPF_TASK:   gp_pick = flags[1];
			GPF_SLICED: gp_pick = flags[2];
			GPF_ZERO:   gp_pick = 1'b0;
			GPF_FILLED: gp_pick = flags[3];
			GPF_OVFL:   gp_pick = flags[4];
			GPF_AFULL:  gp_pick = flags[5];
			default:    gp_pick = flags[5] ^ 1'b1;
		endcase
	endfunction

	// Core-domain registers
	logic [7:0] fmt_q;
	logic [7:0] arb_q;
	logic [7:0] cken_q;
	logic [7:0] rdata_q;
	logic [2:0] stat_s1_q;
	logic [2:0] stat_s2_q;
	wire        wr_fmt  = reg_wr && reg_addr == REG_FMT_POL;
	wire        wr_arb  = reg_wr && reg_addr == REG_FIFO_ARB;
	wire        wr_cken = reg_wr && reg_addr == REG_CLK_EN;
	wire  [7:0] rd_mux  =
		(reg_addr == REG_FMT_POL)  ? fmt_q :
		(reg_addr == REG_FIFO_ARB) ? arb_q :
		(reg_addr == REG_CLK_EN)   ? cken_q :
		(reg_addr == REG_STATUS)   ? {5'h00, stat_s2_q} : 8'h00;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fmt_q   <= RST_FMT_POL;
			arb_q   <= RST_FIFO_ARB;
			cken_q  <= RST_CLK_EN;
			rdata_q <= 8'h00;
		end
		else
		begin
			if (wr_fmt)
				fmt_q <= reg_wdata;
			if (wr_arb)
				arb_q <= reg_wdata;
			if (wr_cken)
				cken_q <= reg_wdata & CLK_EN_RW_MASK;
			if (reg_rd)
				rdata_q <= rd_mux;
		end
	end
	assign reg_rdata = rdata_q;

	// Link reset: asserts at once, releases on the link clock
	logic [1:0] lrst_q;
	wire        lrst = lrst_q[1];
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
			lrst_q <= 2'h3;
		else
			lrst_q <= {lrst_q[0], 1'b0};
	end

	// Settings are quasi-static; a bit may land one link cycle before
	// its neighbours after a write, a glitch software tolerates
	localparam int CW = 29;
	wire  [CW-1:0] cfg_core = {gated_clk_sel, gp1_func_lo, gp0_func_lo, cken_q, arb_q, fmt_q};
	logic [CW-1:0] cfg_s1_q;
	logic [CW-1:0] cfg_q;
	logic          tri_s1_q;
	logic          tri_q;
	always_ff @(posedge link_clk or posedge lrst)
	begin
		if (lrst)
		begin
			cfg_s1_q <= '0;
			cfg_q    <= '0;
			tri_s1_q <= 1'b0;
			tri_q    <= 1'b0;
		end
		else
		begin
			cfg_s1_q <= cfg_core;
			cfg_q    <= cfg_s1_q;
			tri_s1_q <= port_tristate_pin;
			tri_q    <= tri_s1_q;
		end
	end

	wire [7:0] l_fmt  = cfg_q[7:0];
	wire [7:0] l_arb  = cfg_q[15:8];
	wire [7:0] l_cken = cfg_q[23:16];
	wire [2:0] gp0_fn = {l_arb[B_GP0_MSB], cfg_q[25:24]};
	wire [2:0] gp1_fn = {l_arb[B_GP1_MSB], cfg_q[27:26]};
	wire       l_gck_sel = cfg_q[28];
	wire [1:0] swap_sel  = l_fmt[B_SWAP_LO+1 -: 2];
	wire [1:0] full_sel  = l_arb[B_FULL_LO+1 -: 2];
	wire [1:0] empty_sel = l_arb[B_EMPTY_LO+1 -: 2];
	wire [1:0] ock_sel   = l_cken[B_OCK_LO+1 -: 2];
	wire [1:0] gck_sel   = l_cken[B_GCK_LO+1 -: 2];
	ipo_arb_e  arb_mode;
	ipo_pen_e  pen_mode;
	assign arb_mode = ipo_arb_e'(l_arb[B_ARB_LO+1 -: 2]);
	assign pen_mode = ipo_pen_e'(l_cken[B_PEN_LO+1 -: 2]);

	// Threshold compare, evaluated every link cycle
	wire ae_d = (empty_sel == 2'h0) ? fifo_level < AE_LVL0 :
		(empty_sel == 2'h1) ? fifo_level < AE_LVL1 :
		(empty_sel == 2'h2) ? fifo_level < AE_LVL2 : fifo_level == 6'h00;
	wire af_d = (full_sel == 2'h0) ? fifo_level >= AF_LVL0 :
		(full_sel == 2'h1) ? fifo_level >= AF_LVL1 :
		(full_sel == 2'h2) ? fifo_level >= AF_LVL2 : fifo_level >= AF_LVL3;

	// Arbitration: text wins when both are offered in mode both
	wire send_txt = txt_valid && (arb_mode == ARB_TEXT || arb_mode == ARB_BOTH);
	wire send_vid = vid_valid && !send_txt
		&& (arb_mode == ARB_VIDEO || arb_mode == ARB_BOTH);
	wire [31:0] vid_lim;
	genvar gi;
	for (gi = 0; gi < 4; gi++)
	begin : g_lim
		assign vid_lim[gi*8 +: 8] = vid_is_code ? vid_dword[gi*8 +: 8]
			: clip(vid_dword[gi*8 +: 8], l_fmt[B_LIMIT]);
	end
	wire [31:0] word_d = swap(send_txt ? txt_dword : vid_lim, swap_sel);

	// Output enable from software or from the pin
	wire drive_d = (pen_mode == PEN_ON) || (pen_mode == PEN_PIN_LOW && !tri_q)
		|| (pen_mode == PEN_PIN_HIGH && tri_q);

	// Output clock is link/2; a new word launches as it rises, or as it falls when ock_sel[0] is set
	logic        div_q;
	logic        afl_q;
	logic        aem_q;
	logic        valid_q;
	logic        vtake_q;
	logic        ttake_q;
	logic [31:0] data_q;
	logic        qual_q;
	logic        href_q;
	logic        vref_q;
	logic        gp0_q;
	logic        gp1_q;
	logic        pclk_q;
	logic        odly_q;
	logic        gdly_q;
	logic        oe_n_q;
	wire         launch = !div_q;
	wire         valid_d = launch ? (send_txt || send_vid) : valid_q;
	wire  [5:0]  gp_flags = {af_d, fifo_ovfl_in, fifo_filled_in,
		sliced_frame_in, task_flag_in, field_id_in};
	wire  [5:0]  gp_flags_e = {af_d, gp_flags[4:0]};
	wire         gp0_raw = (gp0_fn == 3'h7) ? ae_d : gp_pick(gp0_fn, gp_flags_e);
	wire         gp1_raw = (gp1_fn == 3'h7) ? ae_d : gp_pick(gp1_fn, gp_flags_e);
	// Gated clock follows the next output clock level before the ock_sel[0] inversion, while data is valid
	wire         gclk_d = !div_q && valid_d;
	wire         qual_d = l_gck_sel ? gclk_d ^ gck_sel[0]
		: valid_d ^ l_fmt[B_QUAL_INV];

	always_ff @(posedge link_clk or posedge lrst)
	begin
		if (lrst)
		begin
			div_q   <= 1'b0;
			afl_q   <= 1'b0;
			aem_q   <= 1'b1;
			valid_q <= 1'b0;
			vtake_q <= 1'b0;
			ttake_q <= 1'b0;
			data_q  <= 32'h0000_0000;
			qual_q  <= 1'b0;
			href_q  <= 1'b0;
			vref_q  <= 1'b0;
			gp0_q   <= 1'b0;
			gp1_q   <= 1'b0;
			pclk_q  <= 1'b0;
			odly_q  <= 1'b0;
			gdly_q  <= 1'b0;
			oe_n_q  <= 1'b1;
		end
		else
		begin
			div_q   <= !div_q;
			afl_q   <= af_d;
			aem_q   <= ae_d;
			valid_q <= valid_d;
			vtake_q <= launch && send_vid;
			ttake_q <= launch && send_txt;
			if (launch)
				data_q <= word_d;
			qual_q  <= qual_d;
			href_q  <= href_in ^ l_fmt[B_HREF_INV];
			vref_q  <= vref_in ^ l_fmt[B_VREF_INV];
			gp0_q   <= gp0_raw ^ l_fmt[B_GP0_INV];
			gp1_q   <= gp1_raw ^ l_fmt[B_GP1_INV];
			pclk_q  <= !div_q ^ ock_sel[0];
			odly_q  <= ock_sel[1];
			gdly_q  <= gck_sel[1] && l_gck_sel;
			oe_n_q  <= !drive_d;
		end
	end

	// Flags and pin level reported back to software
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stat_s1_q <= 3'h0;
			stat_s2_q <= 3'h0;
		end
		else
		begin
			stat_s1_q <= {tri_q, afl_q, aem_q};
			stat_s2_q <= stat_s1_q;
		end
	end

	assign vid_take           = vtake_q;
	assign txt_take           = ttake_q;
	assign port_data_out      = data_q;
	assign data_qualifier_out = qual_q;
	assign horiz_ref_out      = href_q;
	assign vert_ref_out       = vref_q;
	assign gp_out0            = gp0_q;
	assign gp_out1            = gp1_q;
	assign port_clock_out     = pclk_q;
	assign out_clk_delay      = odly_q;
	assign gated_clk_delay    = gdly_q;
	assign port_oe_n          = oe_n_q;

	// Checks on the link side
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (lrst);

	chk_clip_narrow: assert property (launch && send_vid && !vid_is_code && l_fmt[B_LIMIT]
		&& swap_sel == 2'h0 |=> data_q[7:0] >= LIM_NARROW_LO && data_q[7:0] <= LIM_NARROW_HI)
		else $error("narrow clip violated");
	chk_swap_reverse: assert property (launch && send_txt && swap_sel == 2'h3
		|=> data_q[7:0] == $past(txt_dword[31:24]))
		else $error("byte reverse wrong");
	chk_qual_polarity: assert property (!l_gck_sel && $stable(l_fmt)
		|=> qual_q == (valid_q ^ $past(l_fmt[B_QUAL_INV])))
		else $error("qualifier polarity wrong");
	chk_href_invert: assert property ($stable(l_fmt)
		|=> href_q == ($past(href_in) ^ $past(l_fmt[B_HREF_INV])))
		else $error("href polarity wrong");
	chk_gp_const_zero: assert property (gp0_fn == 3'h3 && $stable(l_fmt) && $stable(gp0_fn)
		|=> gp0_q == $past(l_fmt[B_GP0_INV]))
		else $error("gp0 constant wrong");
	chk_arb_inhibit: assert property (arb_mode == ARB_OFF [*3] |-> !valid_q && !vtake_q)
		else $error("output not inhibited");
	chk_text_priority: assert property (launch && arb_mode == ARB_BOTH && txt_valid
		|=> ttake_q && !vtake_q)
		else $error("text lost priority");
	chk_empty_zero: assert property (empty_sel == 2'h3 && fifo_level == 6'h01
		|=> !aem_q)
		else $error("empty flag early");
	chk_full_level: assert property (full_sel == 2'h1 && fifo_level == 6'h18
		|=> afl_q)
		else $error("full flag missed");
	chk_oe_soft: assert property (pen_mode == PEN_OFF |=> oe_n_q ##1 oe_n_q || pen_mode != PEN_OFF)
		else $error("driver on while disabled");
	cov_video: cover property (launch && send_vid ##1 vtake_q);
	cov_text_both: cover property (arb_mode == ARB_BOTH && launch && send_txt && vid_valid);
	cov_pin_enable: cover property (pen_mode == PEN_PIN_HIGH && tri_q ##1 !oe_n_q);
endmodule // ipo_top

/* File: sim/ipo_capture.sv */
// Capture-side model of the image port backend
`timescale 1ns/1ns
module ipo_capture
(
	// Link side
	input  wire logic        link_clk,
	input  wire logic [31:0] port_data_out,
	input  wire logic        data_qualifier_out,
	input  wire logic        port_oe_n,
	input  wire logic        qual_low,
	input  wire logic        pin_level,
	// Pin and captured data
	output logic             port_tristate_pin,
	output logic [31:0]      cap_word,
	output int               cap_count
);
	// Backend owns the three-state pin and holds its level between changes
	assign port_tristate_pin = pin_level;
	initial cap_count = 0;
	always @(posedge link_clk)
	begin
		// Undriven pins carry nothing, so only enabled and qualified words count
		if (port_oe_n === 1'b0 && data_qualifier_out === !qual_low)
		begin
			cap_word  <= port_data_out;
			cap_count <= cap_count + 1;
		end
	end
endmodule // ipo_capture

/* File: sim/ipo_top_tb.sv */
// Self-checking bench for the image port output control block
`timescale 1ns/1ns
module ipo_top_tb;
	import ipo_pkg::*;
	logic        clk = 0, rst = 1, link_clk = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, d;
	logic [1:0]  gp0_func_lo = 0, gp1_func_lo = 0, got;
	logic        gated_clk_sel = 0, vid_valid = 0, vid_is_code = 0, txt_valid = 0;
	logic [31:0] vid_dword = 0, txt_dword = 0, port_data_out, cap_word;
	logic        href_in = 0, vref_in = 0, field_id_in = 0, task_flag_in = 0;
	logic        sliced_frame_in = 0, fifo_filled_in = 0, fifo_ovfl_in = 0, pin_level = 0;
	logic [5:0]  fifo_level = 0;
	logic        vid_take, txt_take, port_tristate_pin, data_qualifier_out, horiz_ref_out;
	logic        vert_ref_out, gp_out0, gp_out1, port_clock_out, out_clk_delay;
	logic        gated_clk_delay, port_oe_n, qual_low = 0, a;
	int          cap_count, err_count = 0, checks = 0, c0;
	always #2 clk = ~clk;
	// Link clock of 15 ns, phase unrelated to the core clock
	always
	begin
		#7 link_clk = 1;
		#8 link_clk = 0;
	end
	ipo_top i_ipo_top (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.gp0_func_lo(gp0_func_lo), .gp1_func_lo(gp1_func_lo), .gated_clk_sel(gated_clk_sel),
		.link_clk(link_clk), .vid_dword(vid_dword), .vid_valid(vid_valid),
		.vid_is_code(vid_is_code), .txt_dword(txt_dword), .txt_valid(txt_valid),
		.vid_take(vid_take), .txt_take(txt_take), .href_in(href_in), .vref_in(vref_in),
		.field_id_in(field_id_in), .task_flag_in(task_flag_in),
		.sliced_frame_in(sliced_frame_in), .fifo_filled_in(fifo_filled_in),
		.fifo_ovfl_in(fifo_ovfl_in), .fifo_level(fifo_level),
		.port_tristate_pin(port_tristate_pin), .port_data_out(port_data_out),
		.data_qualifier_out(data_qualifier_out), .horiz_ref_out(horiz_ref_out),
		.vert_ref_out(vert_ref_out), .gp_out0(gp_out0), .gp_out1(gp_out1),
		.port_clock_out(port_clock_out), .out_clk_delay(out_clk_delay),
		.gated_clk_delay(gated_clk_delay), .port_oe_n(port_oe_n));
	ipo_capture i_ipo_capture (.link_clk(link_clk), .port_data_out(port_data_out),
		.data_qualifier_out(data_qualifier_out), .port_oe_n(port_oe_n), .qual_low(qual_low),
		.pin_level(pin_level), .port_tristate_pin(port_tristate_pin), .cap_word(cap_word),
		.cap_count(cap_count));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic lk(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
		@(posedge clk) #1;
		reg_wr = 1;
		reg_addr = ad;
		reg_wdata = wd;
		@(posedge clk) #1;
		reg_wr = 0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] rdv);
		@(posedge clk) #1;
		reg_rd = 1;
		reg_addr = ad;
		@(posedge clk) #1;
		reg_rd = 0;
		@(posedge clk) #1;
		rdv = reg_rdata;
	endtask
	// Offer words and wait a bounded span for a take pulse; both offers drop after it
	task automatic offer(input logic [31:0] vw, input logic vv, input logic [31:0] tw,
		input logic tv, output logic [1:0] tk);
		lk(1);
		vid_dword = vw;
		vid_valid = vv;
		txt_dword = tw;
		txt_valid = tv;
		for (int n = 0; n < 12 && vid_take !== 1'b1 && txt_take !== 1'b1; n++)
			lk(1);
		tk = {txt_take, vid_take};
		vid_valid = 0;
		txt_valid = 0;
	endtask
	function automatic logic [31:0] fmt(input logic [31:0] w, input logic [2:0] f,
		input logic code);
		logic [7:0] b [4];
		for (int i = 0; i < 4; i++)
		begin
			b[i] = w[8*i +: 8];
			if (!code && f[0])
				b[i] = b[i] < 8'h08 ? 8'h08 : (b[i] > 8'hF7 ? 8'hF7 : b[i]);
			else if (!code)
				b[i] = b[i] < 8'h01 ? 8'h01 : (b[i] > 8'hFE ? 8'hFE : b[i]);
		end
		case (f[2:1])
			2'h0: return {b[3], b[2], b[1], b[0]};
			2'h1: return {b[2], b[3], b[0], b[1]};
			2'h2: return {b[1], b[0], b[3], b[2]};
			default: return {b[0], b[1], b[2], b[3]};
		endcase
	endfunction
	task automatic t_regs;
		rd(REG_FMT_POL, d);
		check(d, 8'h00);
		wr(REG_FMT_POL, 8'hA5);
		rd(REG_FMT_POL, d);
		check(d, 8'hA5);
		wr(REG_FIFO_ARB, 8'h3C);
		rd(REG_FIFO_ARB, d);
		check(d, 8'h3C);
		wr(REG_CLK_EN, 8'hFF);
		rd(REG_CLK_EN, d);
		check(d, 8'hF3);
		wr(8'h40, 8'h55);
		rd(8'h40, d);
		check(d, 8'h00);
		$display("registers done");
	endtask
	task automatic t_video;
		wr(REG_CLK_EN, 8'h01);
		wr(REG_FIFO_ARB, 8'h40);
		for (int f = 0; f < 8; f++)
		begin
			wr(REG_FMT_POL, 8'(f << 5));
			lk(6);
			offer(32'h00FF0580, 1, 0, 0, got);
			check(got, 2'h1);
			check(port_data_out, fmt(32'h00FF0580, 3'(f), 0));
			check(data_qualifier_out, 1'b1);
		end
		vid_is_code = 1;
		offer(32'hFF0000AB, 1, 0, 0, got);
		check(port_data_out, fmt(32'hFF0000AB, 3'h7, 1));
		vid_is_code = 0;
		wr(REG_FMT_POL, 8'h01);
		qual_low = 1;
		lk(6);
		c0 = cap_count;
		offer(32'h12345678, 1, 0, 0, got);
		check(data_qualifier_out, 1'b0);
		lk(2);
		check(cap_word, 32'h12345678);
		check(cap_count > c0, 1'b1);
		$display("video done");
	endtask
	task automatic t_arb;
		wr(REG_FIFO_ARB, 8'h00);
		lk(6);
		c0 = cap_count;
		offer(32'h11111111, 1, 32'h22222222, 1, got);
		check(got, 2'h0);
		check(cap_count, c0);
		wr(REG_FIFO_ARB, 8'h80);
		lk(6);
		offer(32'h33333333, 1, 0, 0, got);
		check(got, 2'h0);
		offer(32'h33333333, 1, 32'h00FF0102, 1, got);
		check(got, 2'h2);
		wr(REG_FIFO_ARB, 8'hC0);
		lk(6);
		offer(32'h44444444, 1, 32'h00FF0304, 1, got);
		check(got, 2'h2);
		check(port_data_out, 32'h00FF0304);
		$display("arbitration done");
	endtask
	task automatic t_refs;
		for (int i = 0; i < 4; i++)
		begin
			wr(REG_FMT_POL, 8'(i << 1));
			lk(6);
			href_in = 1;
			vref_in = 0;
			lk(3);
			check(horiz_ref_out, !i[0]);
			check(vert_ref_out, i[1]);
		end
		$display("references done");
	endtask
	task automatic t_gp;
		logic [7:0] exp_gp;
		exp_gp = 8'b0110_0101;
		{field_id_in, sliced_frame_in, fifo_ovfl_in} = 3'h7;
		fifo_level = 20;
		wr(REG_FMT_POL, 8'h08);
		for (int g = 0; g < 8; g++)
		begin
			gp0_func_lo = 2'(g);
			gp1_func_lo = 2'(g);
			wr(REG_FIFO_ARB, {2'h0, g[2], g[2], 4'h0});
			lk(6);
			check(gp_out0, exp_gp[g]);
			check(gp_out1, !exp_gp[g]);
		end
		wr(REG_FMT_POL, 8'h00);
		gp0_func_lo = 2'h3;
		gp1_func_lo = 2'h2;
		for (int c = 0; c < 4; c++)
		begin
			wr(REG_FIFO_ARB, {2'h0, 2'h3, 2'(c), 2'(c)});
			lk(6);
			for (int l = 0; l <= 32; l++)
			begin
				fifo_level = 6'(l);
				lk(3);
				check(gp_out0, c == 3 ? l == 0 : l < (16 >> c));
				check(gp_out1, l >= (c == 0 ? 16 : c == 3 ? 32 : 32 - (16 >> c)));
			end
		end
		// Level 32 with codes 11: almost full set, almost empty clear, pin low
		rd(REG_STATUS, d);
		check(d, 8'h02);
		$display("general purpose done");
	endtask
	task automatic t_pen;
		for (int e = 0; e < 8; e++)
		begin
			wr(REG_CLK_EN, 8'(e >> 1));
			pin_level = e[0];
			lk(8);
			check(port_oe_n, !(e[2:1] == 1 || e[2:1] == 2 && !e[0] || e[2:1] == 3 && e[0]));
		end
		$display("port enable done");
	endtask
	task automatic t_clk;
		wr(REG_CLK_EN, 8'hA1);
		lk(6);
		check({out_clk_delay, gated_clk_delay}, 2'h2);
		gated_clk_sel = 1;
		lk(6);
		check({out_clk_delay, gated_clk_delay}, 2'h3);
		// Half-cycle settings, as software should pick for a gated clock
		wr(REG_CLK_EN, 8'h51);
		lk(6);
		check({out_clk_delay, gated_clk_delay}, 2'h0);
		a = port_clock_out;
		lk(1);
		check(port_clock_out, !a);
		gated_clk_sel = 0;
		$display("clock phase done");
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		lk(3);
		t_regs();
		t_video();
		t_arb();
		t_refs();
		t_gp();
		t_pen();
		t_clk();
		test_done();
	end
	initial
	begin
		#200000;
		err_count++;
		test_done();
	end
endmodule // ipo_top_tb
